// [echm_mapper.sv]
// Event to channel and channel to host interrupt mapper with its registers.
`timescale 1ns/100ps
`default_nettype none

module echm_mapper
  import echm_pkg::*;
#(
  // Set bit n to fix channel n's host select to FIXED_HOST nibble n.
  parameter logic [echm_pkg::ECHM_NUM_CH-1:0]   FIXED_MASK = '0,
  parameter logic [4*echm_pkg::ECHM_NUM_CH-1:0] FIXED_HOST = '0
) (
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic [echm_pkg::ECHM_ADDR_W-1:0] reg_addr,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  input  wire logic [echm_pkg::ECHM_DATA_W-1:0] reg_wdata,
  output logic      [echm_pkg::ECHM_DATA_W-1:0] reg_rdata,
  input  wire logic [echm_pkg::ECHM_NUM_EV-1:0] event_in,
  output logic      [4*echm_pkg::ECHM_NUM_EV-1:0] event_channel_sel,
  output logic      [4*echm_pkg::ECHM_NUM_CH-1:0] channel_host_sel,
  output logic      [echm_pkg::ECHM_NUM_HI-1:0] host_int
);
  import echm_pkg::*;

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  logic [31:0] evch_ff [3];       // Event channel maps, 434h to 43Ch.
  logic [31:0] nxt_evch [3];      // Next values of the event maps.
  logic [31:0] chhs_ff [3];       // Host maps, 800h to 808h.
  logic [31:0] nxt_chhs [3];      // Next values of the host maps.
  logic [31:0] rdata_ff;          // Read data register.
  logic [31:0] nxt_rdata;         // Next read data.
  logic [ECHM_NUM_HI-1:0] host_ff;      // Registered host interrupt lines.
  logic [ECHM_NUM_HI-1:0] nxt_host;     // Next host interrupt lines.
  logic [ECHM_NUM_EV-1:0] ev_s1_ff;     // First synchroniser stage of events.
  logic [ECHM_NUM_EV-1:0] ev_s2_ff;     // Second synchroniser stage of events.
  logic [4*ECHM_NUM_EV-1:0] evsel_ff;   // Registered event channel selects.
  logic [4*ECHM_NUM_CH-1:0] hsel_ff;    // Registered host selects.
  logic [4*ECHM_NUM_EV-1:0] evsel_w;    // Current event channel selects.
  logic [4*ECHM_NUM_CH-1:0] hsel_w;     // Current host selects, fixed ones applied.
  logic [ECHM_NUM_CH-1:0]   ch_act;     // Channels raised this cycle.
  logic [ECHM_NUM_CH-1:0]   ev_hits [ECHM_NUM_EV]; // Per-event channel vectors.
  logic [ECHM_NUM_HI-1:0]   ch_hits [ECHM_NUM_CH]; // Per-channel host vectors.

  // Map a byte offset to a slot of the event map bank, or 3 for none.
  function automatic logic [1:0] evch_slot(input logic [11:0] a);
    unique case (a)
      ECHM_OFS_EVCH_52_55: evch_slot = 2'h0;
      ECHM_OFS_EVCH_56_59: evch_slot = 2'h1;
      ECHM_OFS_EVCH_60_63: evch_slot = 2'h2;
      default:             evch_slot = 2'h3;
    endcase
  endfunction

  // Map a byte offset to a slot of the host map bank, or 3 for none.
  function automatic logic [1:0] chhs_slot(input logic [11:0] a);
    unique case (a)
      ECHM_OFS_CHHS_0_3: chhs_slot = 2'h0;
      ECHM_OFS_CHHS_4_7: chhs_slot = 2'h1;
      ECHM_OFS_CHHS_8_9: chhs_slot = 2'h2;
      default:           chhs_slot = 2'h3;
    endcase
  endfunction

  // ****************************************************************
  // Register write and read.
  // ****************************************************************
  // Whole words are written; reserved nibbles are stored and read back too, but never steer routing.
  always_comb begin
    for (int r = 0; r < 3; r++) begin
      nxt_evch[r] = evch_ff[r];
      nxt_chhs[r] = chhs_ff[r];
    end
    nxt_rdata = rdata_ff;
    if (reg_wr && (evch_slot(reg_addr) != 2'h3)) begin
      nxt_evch[evch_slot(reg_addr)] = reg_wdata;
    end
    if (reg_wr && (chhs_slot(reg_addr) != 2'h3)) begin
      nxt_chhs[chhs_slot(reg_addr)] = reg_wdata;
    end
    if (reg_rd) begin
      if (evch_slot(reg_addr) != 2'h3) begin
        nxt_rdata = evch_ff[evch_slot(reg_addr)];
      end else if (chhs_slot(reg_addr) != 2'h3) begin
        nxt_rdata = chhs_ff[chhs_slot(reg_addr)];
        // Fixed channels read back their hardware value, not the stored one.
        for (int c = 0; c < ECHM_NUM_CH; c++) begin
          if ((c / 4 == int'(chhs_slot(reg_addr))) && FIXED_MASK[c]) begin
            nxt_rdata[ECHM_FIELD_POS0 + ECHM_FIELD_STEP*(c%4) +: ECHM_SEL_W] =
              FIXED_HOST[4*c +: 4];
          end
        end
      end else begin
        nxt_rdata = 32'h0000_0000; // Unmapped offsets read as zero.
      end
    end
  end

  // Storage flops; reset clears every field.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int r = 0; r < 3; r++) begin
        evch_ff[r] <= ECHM_RESET_VAL;
        chhs_ff[r] <= ECHM_RESET_VAL;
      end
      rdata_ff <= ECHM_RESET_VAL;
    end else begin
      for (int r = 0; r < 3; r++) begin
        evch_ff[r] <= nxt_evch[r];
        chhs_ff[r] <= nxt_chhs[r];
      end
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // Field extraction.
  // ****************************************************************
  // Only the select nibbles are picked out, so reserved bits cannot steer routing.
  always_comb begin
    for (int e = 0; e < ECHM_NUM_EV; e++) begin
      evsel_w[4*e +: 4] =
        evch_ff[e/4][ECHM_FIELD_POS0 + ECHM_FIELD_STEP*(e%4) +: ECHM_SEL_W];
    end
    for (int c = 0; c < ECHM_NUM_CH; c++) begin
      hsel_w[4*c +: 4] = FIXED_MASK[c] ? FIXED_HOST[4*c +: 4] :
        chhs_ff[c/4][ECHM_FIELD_POS0 + ECHM_FIELD_STEP*(c%4) +: ECHM_SEL_W];
    end
  end

  // ****************************************************************
  // Routing.
  // ****************************************************************
  // Each event decodes to at most one channel, each channel to at most one host line.
  genvar g;
  generate
    for (g = 0; g < ECHM_NUM_EV; g++) begin : g_ev
      echm_onehot_route #(.OUT_N(ECHM_NUM_CH)) u_ev (
        .sel (evsel_w[4*g +: 4]),
        .req (ev_s2_ff[g]),
        .hit (ev_hits[g])
      );
    end
    for (g = 0; g < ECHM_NUM_CH; g++) begin : g_ch
      echm_onehot_route #(.OUT_N(ECHM_NUM_HI)) u_ch (
        .sel (hsel_w[4*g +: 4]),
        .req (ch_act[g]),
        .hit (ch_hits[g])
      );
    end
  endgenerate

  // Values of ten and up route nowhere, which keeps them harmless.
  always_comb begin
    ch_act = '0;
    nxt_host = '0;
    for (int e = 0; e < ECHM_NUM_EV; e++) begin
      ch_act = ch_act | ev_hits[e];
    end
    for (int c = 0; c < ECHM_NUM_CH; c++) begin
      nxt_host = nxt_host | ch_hits[c];
    end
  end

  // Events come from other logic domains, so they are synchronised first.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ev_s1_ff <= '0;
      ev_s2_ff <= '0;
      host_ff  <= '0;
      evsel_ff <= '0;
      hsel_ff  <= '0;
    end else begin
      ev_s1_ff <= event_in;
      ev_s2_ff <= ev_s1_ff;
      host_ff  <= nxt_host;
      evsel_ff <= evsel_w;
      hsel_ff  <= hsel_w;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign reg_rdata         = rdata_ff;
  assign host_int          = host_ff;
  assign event_channel_sel = evsel_ff;
  assign channel_host_sel  = hsel_ff;

endmodule : echm_mapper
`default_nettype wire

// [echm_pkg.sv]
// Package of constants for the event channel host mapper.
package echm_pkg;

  // ****************************************************************
  // Bus and field widths.
  // ****************************************************************
  localparam int unsigned ECHM_ADDR_W  = 12;  // Byte address width of the register port.
  localparam int unsigned ECHM_DATA_W  = 32;  // Register data width.
  localparam int unsigned ECHM_SEL_W   = 4;   // Width of each select nibble.
  localparam int unsigned ECHM_NUM_EV  = 12;  // Covered system events 52 to 63.
  localparam int unsigned ECHM_NUM_CH  = 10;  // Channels 0 to 9.
  localparam int unsigned ECHM_NUM_HI  = 10;  // Host interrupts 0 to 9.
  localparam int unsigned ECHM_FIRST_EV = 52; // Lowest covered system event.

  // ****************************************************************
  // Register offsets.
  // ****************************************************************
  localparam logic [11:0] ECHM_OFS_EVCH_52_55 = 12'h434;
  localparam logic [11:0] ECHM_OFS_EVCH_56_59 = 12'h438;
  localparam logic [11:0] ECHM_OFS_EVCH_60_63 = 12'h43c;
  localparam logic [11:0] ECHM_OFS_CHHS_0_3   = 12'h800;
  localparam logic [11:0] ECHM_OFS_CHHS_4_7   = 12'h804;
  localparam logic [11:0] ECHM_OFS_CHHS_8_9   = 12'h808;

  // ****************************************************************
  // Field positions and reset value.
  // ****************************************************************
  localparam int unsigned ECHM_FIELD_POS0 = 0;   // First select field, bits 3-0.
  localparam int unsigned ECHM_FIELD_STEP = 8;   // Next field eight bits higher.
  localparam logic [31:0] ECHM_RESET_VAL  = 32'h0000_0000;

endpackage : echm_pkg

// [echm_onehot_route.sv]
// Decoder that turns a select nibble and a request into a one-hot vector.
`timescale 1ns/100ps
`default_nettype none

module echm_onehot_route #(
  parameter int unsigned OUT_N = 10
) (
  input  wire logic [3:0]       sel,   // Chosen destination number.
  input  wire logic             req,   // Request to route.
  output logic      [OUT_N-1:0] hit    // One-hot destination vector.
);

  // ****************************************************************
  // Decode.
  // ****************************************************************
  // Numbers beyond the last destination raise nothing; software is told not to use them.
  always_comb begin
    hit = '0;
    for (int i = 0; i < OUT_N; i++) begin
      if (req && (sel == 4'(i))) begin
        hit[i] = 1'b1;
      end
    end
  end

endmodule : echm_onehot_route
`default_nettype wire

// [echm_mapper_assertions.sv]
// Checker of the mapper's register writes, reset values and event routing.
`timescale 1ns/100ps
`default_nettype none
module echm_mapper_assertions #(
  parameter logic [echm_pkg::ECHM_NUM_CH-1:0]   FIXED_MASK = '0,
  parameter logic [4*echm_pkg::ECHM_NUM_CH-1:0] FIXED_HOST = '0
) (
  input wire logic                               clk,
  input wire logic                               reset,
  input wire logic [echm_pkg::ECHM_ADDR_W-1:0]   reg_addr,
  input wire logic                               reg_wr,
  input wire logic                               reg_rd,
  input wire logic [echm_pkg::ECHM_DATA_W-1:0]   reg_wdata,
  input wire logic [echm_pkg::ECHM_DATA_W-1:0]   reg_rdata,
  input wire logic [echm_pkg::ECHM_NUM_EV-1:0]   event_in,
  input wire logic [4*echm_pkg::ECHM_NUM_EV-1:0] event_channel_sel,
  input wire logic [4*echm_pkg::ECHM_NUM_CH-1:0] channel_host_sel,
  input wire logic [echm_pkg::ECHM_NUM_HI-1:0]   host_int
);
  import echm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Gathers the four select fields of a word; the reserved nibbles drop out.
  function automatic logic [15:0] fld(input logic [31:0] d);
    return {d[27:24], d[19:16], d[11:8], d[3:0]};
  endfunction
  // An event held long enough to pass the two-flop synchroniser and the route.
  sequence ev_held;
    (event_in[0] && event_channel_sel[3:0] == 4'h0 && channel_host_sel[3:0] == 4'h2) [*4];
  endsequence
  sequence ev_quiet;
    (event_in == '0) [*4];
  endsequence
  // The word lands in storage at the write edge and reaches the select outputs one edge later.
  a_low_group_write: assert property ((reg_wr && reg_addr == ECHM_OFS_EVCH_52_55) |=>
    ##1 event_channel_sel[15:0] == fld($past(reg_wdata, 2))) else $error("events 52-55 select wrong");
  a_mid_group_write: assert property ((reg_wr && reg_addr == ECHM_OFS_EVCH_56_59) |=>
    ##1 event_channel_sel[31:16] == fld($past(reg_wdata, 2))) else $error("events 56-59 select wrong");
  a_top_group_write: assert property ((reg_wr && reg_addr == ECHM_OFS_EVCH_60_63) |=>
    ##1 event_channel_sel[47:32] == fld($past(reg_wdata, 2))) else $error("events 60-63 select wrong");
  a_host_map_write: assert property ((reg_wr && reg_addr == ECHM_OFS_CHHS_0_3 &&
    FIXED_MASK[2:0] == 3'h0) |=> ##1 channel_host_sel[11:0] == {$past(reg_wdata[19:16], 2),
    $past(reg_wdata[11:8], 2), $past(reg_wdata[3:0], 2)}) else $error("channel 0-2 host select wrong");
  a_fixed_host_kept: assert property ((reg_wr && reg_addr == ECHM_OFS_CHHS_0_3 &&
    FIXED_MASK[3]) |=> channel_host_sel[15:12] == FIXED_HOST[15:12]) else $error("fixed host lost");
  a_reset_clears: assert property (disable iff (1'b0) reset |-> event_channel_sel == '0 &&
    channel_host_sel == '0 && host_int == '0) else $error("outputs not cleared in reset");
  a_select_holds: assert property (!reg_wr [*2] |=> $stable(event_channel_sel))
    else $error("event select changed without a write");
  a_event_routed: assert property (ev_held |=> host_int[2])
    else $error("event 52 not routed to host 2");
  a_quiet_no_int: assert property (ev_quiet |=> host_int == '0)
    else $error("host interrupt without an event");
endmodule // echm_mapper_assertions
bind echm_mapper echm_mapper_assertions #(.FIXED_MASK(FIXED_MASK), .FIXED_HOST(FIXED_HOST)) u_chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_in(event_in),
  .event_channel_sel(event_channel_sel), .channel_host_sel(channel_host_sel), .host_int(host_int));
`default_nettype wire

// [echm_host_model.sv]
// Model of the cores that receive the host interrupt levels.
`timescale 1ns/100ps
`default_nettype none
module echm_host_model (
  input  wire logic [0:0]                      clk,
  input  wire logic                            reset,
  input  wire logic [echm_pkg::ECHM_NUM_HI-1:0] host_int,
  output logic      [echm_pkg::ECHM_NUM_HI-1:0] seen_ff
);
  import echm_pkg::*;
  logic [ECHM_NUM_HI-1:0] nxt_seen;  // Sticky record of every line seen high.
  // The cores latch each level so that a short assertion is not missed.
  always_comb nxt_seen = seen_ff | host_int;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) seen_ff <= '0;
    else seen_ff <= nxt_seen;
  end
endmodule // echm_host_model
`default_nettype wire

// [echm_mapper_test.sv]
// Self-checking bench of the event channel host mapper.
`timescale 1ns/100ps
`default_nettype none
module echm_mapper_test;
  import echm_pkg::*;
  // One row: offset, written word, value after reset, value read back.
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] z; logic [31:0] q;} echm_row_t;
  logic        clk = 1'b0, reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = '0, event_in = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [47:0] ev_sel;
  logic [39:0] ch_sel;
  logic [9:0]  host_int, seen;
  int          bad_count = 0, compares = 0;
  // Channel 3 is fixed to host 5, so its field must ignore the write.
  echm_row_t rows [7] = '{
    '{12'h434, 32'h9382_7160, 32'h0, 32'h9382_7160}, '{12'h438, 32'h0504_0706, 32'h0, 32'h0504_0706},
    '{12'h43c, 32'hf908_e001, 32'h0, 32'hf908_e001}, '{12'h800, 32'h0701_0302, 32'h0500_0000,
    32'h0501_0302}, '{12'h804, 32'h0406_0809, 32'h0, 32'h0406_0809},
    '{12'h808, 32'hab00_0504, 32'h0, 32'hab00_0504}, '{12'h440, 32'hffff_ffff, 32'h0, 32'h0}};
  echm_mapper #(.FIXED_MASK(10'h008), .FIXED_HOST(40'h00_0000_5000)) DUT (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_in(event_in),
    .event_channel_sel(ev_sel), .channel_host_sel(ch_sel), .host_int(host_int));
  echm_host_model u_host (.clk(clk), .reset(reset), .host_int(host_int), .seen_ff(seen));
  initial forever #50 clk = ~clk;
  task automatic summarize;
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One register access; strobes drop at the edge that takes them.
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  // Bounded wait for the host lines; running out ends the run.
  task automatic wait_host(input logic [9:0] exp);
    int n;
    n = 0;
    while (host_int !== exp && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(host_int, exp);
    if (n == 10 && host_int !== exp) summarize();
  endtask
  initial begin
    // A real rising edge on reset, so the asynchronous clear fires at start-up.
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      acc(1'b0, rows[i].a, 32'h0);
      check(reg_rdata, rows[i].z);
      acc(1'b1, rows[i].a, rows[i].d);
      acc(1'b0, rows[i].a, 32'h0);
      check(reg_rdata, rows[i].q);
    end
    check(ev_sel, 48'h9801_5476_3210);
    check(ch_sel, 40'h54_4689_5132);
    @(posedge clk);
    event_in <= 12'h009;
    wait_host(10'h024);
    // The cores latch the level one edge after it appears.
    @(posedge clk);
    #1;
    check(seen, 10'h024);
    @(posedge clk);
    event_in <= 12'h000;
    wait_host(10'h000);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    #1;
    check(ev_sel, 48'h0);
    summarize();
  end
endmodule // echm_mapper_test
`default_nettype wire
